// ---- hdl/sbcwd_ctrl_regs.sv ----
`timescale 1ns/100ps
// hardware and watchdog control registers
module sbcwd_ctrl_regs (
	// clock and reset (reset acts as power-on)
	input  wire logic               i_mclk,
	input  wire logic               i_sys_rst,
	// serial interface access
	input  wire sbcwd_pkg::sbcwd_req_t i_req,
	output logic [7:0]              o_rdata,
	output logic                    o_csum_err,
	// device events and state
	input  wire sbcwd_pkg::sbcwd_evt_t i_evt,
	input  wire logic [1:0]         i_cfg_lock,
	input  wire logic               i_pin_is_fo,
	input  wire logic               i_failure_flag,
	// controls to the rest of the device
	output logic                    o_soft_reset,
	output logic                    o_reset_pull,
	output logic                    o_fail_output,
	output logic                    o_charge_pump_en,
	output logic                    o_wd_escalate,
	output logic                    o_wd_stop_disable,
	output logic                    o_wd_window,
	output logic                    o_wd_bus_start,
	output logic [2:0]              o_watchdog_period,
	output logic [15:0]             o_wd_period_ms
);
	import sbcwd_pkg::*;

	logic [7:0]  hw_q;
	logic [7:0]  hw_d;
	logic [7:0]  wd_q;
	logic [7:0]  wd_d;
	logic        wk_q;
	logic        wk_d;
	logic        srst_q;
	logic        rpull_q;
	logic        fo_q;
	logic        csum_err_q;
	logic        busst_q;
	logic [7:0]  rdata_q;
	logic [7:0]  rdata_d;
	logic [15:0] per_ms_q;
	logic [15:0] per_ms_d;

	// next-value pieces, one named wire per source
	logic [7:0]  hw_lock_mask;
	logic [7:0]  hw_soft;
	logic [7:0]  hw_restart;
	logic [7:0]  hw_write;
	logic [7:0]  wd_restart;
	logic [7:0]  wd_base;
	logic [7:0]  wd_load;
	logic [7:0]  wd_write;

	// strobe next values
	logic        rpull_d;
	logic        fo_d;
	logic        csum_err_d;
	logic        busst_d;

	// named register fields
	logic        hw_srr;
	logic        hw_fo;
	logic        hw_cp;
	logic        hw_fcs;
	logic        wd_stop;
	logic        window_type_select;
	logic        wd_bus;
	logic [2:0]  wd_per;

	// address decode
	logic wr_hw;
	logic wr_wd;
	logic wr_wk;
	logic wr_mode;
	logic soft_rst;
	logic restart;
	logic wd_even;
	logic wd_wr_ok;

	assign wr_hw   = i_req.wr && (i_req.addr == ADDR_HW_CTRL);
	assign wr_wd   = i_req.wr && (i_req.addr == ADDR_WATCHDOG_CONTROL);
	assign wr_wk   = i_req.wr && (i_req.addr == ADDR_WAKE_CTRL);
	assign wr_mode = i_req.wr && (i_req.addr == ADDR_MODE_SUPPLY);
	assign restart = i_evt.restart_entry;

	// [RULE_15] mode soft reset
	assign soft_rst = wr_mode && (i_req.data[7:6] == MODE_SOFT_RESET);

	// checksum of the written watchdog byte
	sbcwd_parity u_parity (
		.i_byte (i_req.data),
		.o_even (wd_even)
	);

	// [RULE_09] odd-parity writes are refused
	assign wd_wr_ok = wr_wd && wd_even;

	// [RULE_07] lock bits pick which bits survive a soft reset
	assign hw_lock_mask = ({7'h00, i_cfg_lock[1]} << HW_SRR_BIT)
		| ({7'h00, i_cfg_lock[0]} << HW_CP_BIT);

	// [RULE_08] soft reset clears all but the locked bits
	assign hw_soft = (HW_RESET_VAL & ~hw_lock_mask) | (hw_q & hw_lock_mask);

	// [RULE_06] restart drops the software fail bit with the rest
	// [RULE_08] restart keeps 6, 2, 0
	assign hw_restart = hw_q & HW_RESTART_KEEP;

	// [RULE_14] reserved bits never take written ones
	assign hw_write = i_req.data & HW_WR_MASK;

	// soft reset beats a write, a write beats the restart clear
	assign hw_d = soft_rst ? hw_soft
		: (wr_hw ? hw_write
		: (restart ? hw_restart : hw_q));

	// [RULE_13] restart clears 6 and 3, keeps 7, 5, 4, reloads period
	assign wd_restart = (wd_q & WD_RESTART_KEEP) | {5'h00, WD_RESTART_PER};
	assign wd_base    = restart ? wd_restart : wd_q;

	// [RULE_17] device period load lands on top of a restart
	assign wd_load = i_evt.period_load ? {wd_base[7:3], i_evt.period_val}
		: wd_base;

	// [RULE_14] reserved bit stays zero
	assign wd_write = i_req.data & WD_WR_MASK;

	// [RULE_13] soft reset value; a good write beats device updates
	assign wd_d = soft_rst ? WD_RESET_VAL
		: (wd_wr_ok ? wd_write : wd_load);

	// second stop-mode bit; a write in the same cycle wins the clear
	always_comb begin
		wk_d = wk_q;
		if (soft_rst) begin
			wk_d = WK_RESET_VAL[WK_STOP_BIT];
		end else if (wr_wk) begin
			wk_d = i_req.data[WK_STOP_BIT];
		end else if (i_evt.stop_to_normal || restart) begin
			// [RULE_16] cleared leaving stop
			wk_d = 1'b0;
		end
	end

	// read mux returns the state before any write in this cycle
	always_comb begin
		rdata_d = 8'h00;
		if (i_req.addr == ADDR_HW_CTRL) begin
			rdata_d = hw_q;
		end else if (i_req.addr == ADDR_WATCHDOG_CONTROL) begin
			rdata_d = wd_q;
		end else if (i_req.addr == ADDR_WAKE_CTRL) begin
			rdata_d = {5'h00, wk_q, 2'h0};
		end
	end

	// register storage
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			hw_q <= HW_RESET_VAL;
			wd_q <= WD_RESET_VAL;
			wk_q <= 1'b0;
		end else begin
			hw_q <= hw_d;
			wd_q <= wd_d;
			wk_q <= wk_d;
		end
	end

	// read data only moves on a read strobe
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			rdata_q <= 8'h00;
		end else if (i_req.rd) begin
			rdata_q <= rdata_d;
		end
	end

	// named fields, so the strobes below read like the rules
	assign hw_srr  = hw_q[HW_SRR_BIT];
	assign hw_fo   = hw_q[HW_FO_BIT];
	assign hw_cp   = hw_q[HW_CP_BIT];
	assign hw_fcs  = hw_q[HW_FCS_BIT];
	assign wd_stop = wd_q[WD_STOP_BIT];
	assign window_type_select  = wd_q[WINDOW_TYPE_SELECT_BIT];
	assign wd_bus  = wd_q[WD_BUS_BIT];
	assign wd_per  = wd_q[2:0];

	// [RULE_01] reset pull reads bit 6 before the soft reset clears it
	assign rpull_d = soft_rst & ~hw_srr;

	// [RULE_02] software request gated by pin use
	// [RULE_05] failure flag holds output whatever software asks
	assign fo_d = (hw_fo & i_pin_is_fo) | i_failure_flag;

	// [RULE_09] odd-parity byte is refused and reported
	assign csum_err_d = wr_wd & ~wd_even;

	// [RULE_12] bus wake starts watchdog only when armed
	assign busst_d = i_evt.can_wake_stop & wd_bus;

	// [RULE_17] table lookup; one cycle behind the field, off the
	// write path so the decode stays shallow
	assign per_ms_d = WD_PERIOD_MS[wd_per];

	// soft reset strobes; pulses only, stretching is done outside
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			srst_q  <= 1'b0;
			rpull_q <= 1'b0;
		end else begin
			srst_q  <= soft_rst;
			rpull_q <= rpull_d;
		end
	end

	// fail output registered so a glitch never reaches the pin
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			fo_q <= 1'b0;
		end else begin
			fo_q <= fo_d;
		end
	end

	// checksum error and bus-wake start strobes
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			csum_err_q <= 1'b0;
			busst_q    <= 1'b0;
		end else begin
			csum_err_q <= csum_err_d;
			busst_q    <= busst_d;
		end
	end

	// period in ms, reset to the entry of the reset period
	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			per_ms_q <= WD_PERIOD_MS[WD_RESET_VAL[2:0]];
		end else begin
			per_ms_q <= per_ms_d;
		end
	end

	// [RULE_04] failure count select
	sbcwd_fail_count u_fail_count (
		.i_mclk       (i_mclk),
		.i_sys_rst    (i_sys_rst),
		.i_clear      (soft_rst | restart),
		.i_fail       (i_evt.wd_trig_fail),
		.i_first_only (hw_fcs),
		.o_escalate   (o_wd_escalate)
	);

	// outputs straight from register bits, except stop-mode deactivation, the AND of two bits
	assign o_rdata           = rdata_q;
	assign o_csum_err        = csum_err_q;
	assign o_soft_reset      = srst_q;
	assign o_reset_pull      = rpull_q;
	assign o_fail_output     = fo_q;
	// [RULE_03] charge pump enable
	assign o_charge_pump_en  = hw_cp;
	// [RULE_10] stop-mode deactivation needs both bits
	assign o_wd_stop_disable = wd_stop & wk_q;
	// [RULE_11] watchdog type
	assign o_wd_window       = window_type_select;
	assign o_wd_bus_start    = busst_q;
	assign o_watchdog_period = wd_per;
	assign o_wd_period_ms    = per_ms_q;
endmodule

// ---- hdl/sbcwd_fail_count.sv ----
`timescale 1ns/100ps
// counts watchdog trigger failures up to the escalation point
module sbcwd_fail_count (
	// clock and reset
	input  wire logic i_mclk,
	input  wire logic i_sys_rst,
	// control
	input  wire logic i_clear,
	input  wire logic i_fail,
	input  wire logic i_first_only,
	// escalation pulse
	output logic      o_escalate
);
	import sbcwd_pkg::*;

	logic seen_q;
	logic seen_d;
	logic esc_q;
	logic esc_d;
	logic hit;

	// escalate on the first failure or on the second one
	assign hit    = i_fail & (i_first_only | seen_q);
	assign seen_d = i_clear ? 1'b0 : (hit ? 1'b0 : (seen_q | i_fail));
	assign esc_d  = hit & ~i_clear;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			seen_q <= 1'b0;
			esc_q  <= 1'b0;
		end else begin
			seen_q <= seen_d;
			esc_q  <= esc_d;
		end
	end

	assign o_escalate = esc_q;
endmodule

// ---- hdl/sbcwd_parity.sv ----
`timescale 1ns/100ps
// even-parity check of a written watchdog byte
module sbcwd_parity (
	// data in
	input  wire logic [7:0] i_byte,
	// result
	output logic            o_even
);
	import sbcwd_pkg::*;

	// xor of all bits is zero for even parity
	assign o_even = ~(^i_byte);
endmodule

// ---- hdl/sbcwd_pkg.sv ----
// What this block does
// [RULE_01] Soft-reset reset-control bit 6 at 0 pulls the reset output low on a soft reset, at 1 leaves it alone.
// [RULE_02] Software fail-output bit 5 at 1 drives the fail output only when the pin is set up as fail output.
// [RULE_03] Charge-pump enable bit 2 turns the charge pump output on at 1 and off at 0.
// [RULE_04] Failure-count select bit 0 escalates after the second watchdog failure at 0, after the first at 1.
// [RULE_05] Clearing the software fail-output bit never releases a fail output held by a failure flag.
// [RULE_06] Entering restart clears the software fail-output bit, releasing the output unless a failure holds it.
// [RULE_07] Lock bit 1 keeps bit 6 and lock bit 0 keeps bit 2 of the hardware control register over a soft reset.
// [RULE_08] Hardware control clears on power-on or soft reset (locked bits aside) and keeps bits 6, 2, 0 on restart.
// [RULE_09] The host writes the watchdog control byte with bit 7 chosen so all eight bits have even parity.
// [RULE_10] Stop-mode deactivation bit 6 keeps the watchdog running in stop mode at 0 and stops it at 1; the code also needs the second stop-mode bit set.
// [RULE_11] Watchdog type bit 5 selects time-out operation at 0 and window operation at 1.
// [RULE_12] Bus-wake start bit 4 at 1 lets a CAN wake in stop mode start the watchdog with a long open window.
// [RULE_13] Watchdog control resets to 0x14, and on restart clears bits 6 and 3, loads 100 into 2:0, keeps 7, 5, 4.
// [RULE_14] Reserved bits 7, 4:3, 1 of hardware control and bit 3 of watchdog control always read 0.
// [RULE_15] Writing 11 to the mode field executes a soft reset whose reset output follows bit 6.
// [RULE_16] The second stop-mode deactivation bit is cleared by the device on a change from stop to normal mode.
// [RULE_17] The watchdog period field in bits 2:0 can be loaded by the device and maps through a parameter table.
package sbcwd_pkg;

	// register addresses on the serial interface
	localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
	localparam logic [6:0] ADDR_HW_CTRL     = 7'h02;
	localparam logic [6:0] ADDR_WATCHDOG_CONTROL     = 7'h03;
	localparam logic [6:0] ADDR_WAKE_CTRL   = 7'h06;

	// hardware control field positions
	localparam int HW_SRR_BIT  = 6;
	localparam int HW_FO_BIT   = 5;
	localparam int HW_CP_BIT   = 2;
	localparam int HW_FCS_BIT  = 0;
	localparam logic [7:0] HW_WR_MASK      = 8'h65;
	localparam logic [7:0] HW_RESTART_KEEP = 8'h45;
	localparam logic [7:0] HW_RESET_VAL    = 8'h00;

	// watchdog control field positions
	localparam int WD_CSUM_BIT = 7;
	localparam int WD_STOP_BIT = 6;
	localparam int WINDOW_TYPE_SELECT_BIT  = 5;
	localparam int WD_BUS_BIT  = 4;
	localparam logic [7:0] WD_WR_MASK      = 8'hF7;
	localparam logic [7:0] WD_RESTART_KEEP = 8'hB0;
	localparam logic [7:0] WD_RESET_VAL    = 8'h14;
	localparam logic [2:0] WD_RESTART_PER  = 3'h4;

	// wake control: only the second stop-mode bit lives here
	localparam int WK_STOP_BIT = 2;
	localparam logic [7:0] WK_RESET_VAL = 8'h00;

	// mode field value that requests a soft reset
	localparam logic [1:0] MODE_SOFT_RESET = 2'h3;

	// watchdog period table in ms, indexed by the period field
	localparam logic [15:0] WD_PERIOD_MS [8] = '{
		16'h000A, 16'h0014, 16'h0032, 16'h0064,
		16'h00C8, 16'h01F4, 16'h03E8, 16'h2710
	};

	// decoded serial interface access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [6:0] addr;
		logic [7:0] data;
	} sbcwd_req_t;

	// event strobes from the rest of the device
	typedef struct packed {
		logic       restart_entry;
		logic       stop_to_normal;
		logic       can_wake_stop;
		logic       wd_trig_fail;
		logic       period_load;
		logic [2:0] period_val;
	} sbcwd_evt_t;

endpackage

// ---- tb/sbcwd_ctrl_regs_bench.sv ----
`timescale 1ns/100ps
// directed run over both control registers
module sbcwd_ctrl_regs_bench;
	import sbcwd_pkg::*;
	logic       i_mclk, i_sys_rst, i_pin_is_fo, i_failure_flag;
	logic [1:0] i_cfg_lock;
	sbcwd_req_t i_req;
	sbcwd_evt_t i_evt;
	logic [7:0] o_rdata, r;
	logic       o_csum_err, o_soft_reset, o_reset_pull, o_fail_output;
	logic       o_charge_pump_en, o_wd_escalate, o_wd_stop_disable;
	logic       o_wd_window, o_wd_bus_start;
	logic [2:0] o_watchdog_period;
	logic [15:0] o_wd_period_ms;
	int         n_fail, samples_checked;
	sbcwd_ctrl_regs dut (.i_mclk, .i_sys_rst, .i_req, .o_rdata,
		.o_csum_err, .i_evt, .i_cfg_lock, .i_pin_is_fo, .i_failure_flag,
		.o_soft_reset, .o_reset_pull, .o_fail_output, .o_charge_pump_en,
		.o_wd_escalate, .o_wd_stop_disable, .o_wd_window, .o_wd_bus_start,
		.o_watchdog_period, .o_wd_period_ms);
	sbcwd_host u_host (.i_mclk, .o_req(i_req), .i_rdata(o_rdata));
	// 250 MHz
	initial begin
		i_mclk = 1'b0;
		forever #2 i_mclk = ~i_mclk;
	end
	// compare and count
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
		u_host.rd(a, r);
		chk(r, exp);
	endtask
	// one-cycle device event
	task automatic ev(input logic [7:0] e);
		@(posedge i_mclk);
		i_evt <= e;
		@(posedge i_mclk);
		i_evt <= '0;
		#1;
	endtask
	task print_verdict;
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		{i_sys_rst, i_pin_is_fo, i_failure_flag} = 3'h6;
		{i_evt, i_cfg_lock} = '0;
		{n_fail, samples_checked} = '0;
		repeat (8) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		// reset values, unmapped place reads empty
		rchk(ADDR_HW_CTRL, 8'h00);
		rchk(ADDR_WATCHDOG_CONTROL, 8'h14);
		rchk(7'h05, 8'h00);
		chk(o_wd_period_ms, WD_PERIOD_MS[WD_RESET_VAL[2:0]]);
		u_host.wr(ADDR_HW_CTRL, 8'hFF);
		chk(o_charge_pump_en, 1'b1);
		rchk(ADDR_HW_CTRL, 8'h65);
		chk(o_fail_output, 1'b1);
		@(posedge i_mclk) i_pin_is_fo <= 1'b0;
		rchk(ADDR_HW_CTRL, 8'h65);
		chk(o_fail_output, 1'b0);
		@(posedge i_mclk) i_pin_is_fo <= 1'b1;
		// watchdog byte, stop-mode pair, refused odd byte
		u_host.wd_wr(8'h7F);
		rchk(ADDR_WATCHDOG_CONTROL, 8'hF7);
		chk(o_wd_window, 1'b1);
		u_host.wr(ADDR_WAKE_CTRL, 8'h04);
		chk(o_wd_stop_disable, 1'b1);
		ev(8'h40);
		chk(o_wd_stop_disable, 1'b0);
		u_host.wr(ADDR_WATCHDOG_CONTROL, 8'h01);
		chk(o_csum_err, 1'b1);
		rchk(ADDR_WATCHDOG_CONTROL, 8'hF7);
		// restart keeps only the listed bits
		ev(8'h80);
		rchk(ADDR_HW_CTRL, 8'h45);
		rchk(ADDR_WATCHDOG_CONTROL, 8'hB4);
		chk(o_fail_output, 1'b0);
		@(posedge i_mclk) i_failure_flag <= 1'b1;
		u_host.wr(ADDR_HW_CTRL, 8'h44);
		rchk(ADDR_HW_CTRL, 8'h44);
		chk(o_fail_output, 1'b1);
		@(posedge i_mclk) i_failure_flag <= 1'b0;
		ev(8'h20);
		chk(o_wd_bus_start, 1'b1);
		ev(8'h0A);
		chk(o_watchdog_period, 3'h2);
		@(posedge i_mclk);
		#1 chk(o_wd_period_ms, WD_PERIOD_MS[2]);
		// escalation after second, then after first failure
		ev(8'h10);
		chk(o_wd_escalate, 1'b0);
		ev(8'h10);
		chk(o_wd_escalate, 1'b1);
		u_host.wr(ADDR_HW_CTRL, 8'h45);
		ev(8'h10);
		chk(o_wd_escalate, 1'b1);
		// soft resets: reset output choice and locked bits
		u_host.wr(ADDR_MODE_SUPPLY, 8'hC0);
		chk(o_soft_reset, 1'b1);
		chk(o_reset_pull, 1'b0);
		rchk(ADDR_HW_CTRL, 8'h00);
		rchk(ADDR_WATCHDOG_CONTROL, 8'h14);
		u_host.wr(ADDR_MODE_SUPPLY, 8'hC0);
		chk(o_reset_pull, 1'b1);
		@(posedge i_mclk) i_cfg_lock <= 2'h3;
		u_host.wr(ADDR_HW_CTRL, 8'h44);
		u_host.wr(ADDR_MODE_SUPPLY, 8'hC0);
		rchk(ADDR_HW_CTRL, 8'h44);
		print_verdict();
	end
endmodule

// ---- tb/sbcwd_ctrl_regs_chk.sv ----
`timescale 1ns/100ps
// port-level watch over the control registers
module sbcwd_ctrl_regs_chk (
	// clock and reset
	input wire logic                  i_mclk,
	input wire logic                  i_sys_rst,
	// access and levels
	input wire sbcwd_pkg::sbcwd_req_t i_req,
	input wire logic                  i_pin_is_fo,
	input wire logic                  i_failure_flag,
	// watched outputs
	input wire logic [7:0]            o_rdata,
	input wire logic                  o_csum_err,
	input wire logic                  o_soft_reset,
	input wire logic                  o_fail_output,
	input wire logic                  o_charge_pump_en,
	input wire logic                  o_wd_window
);
	import sbcwd_pkg::*;
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (i_sys_rst);
	// decoded accesses
	wire logic hw_wr = i_req.wr && i_req.addr == ADDR_HW_CTRL;
	wire logic wd_wr = i_req.wr && i_req.addr == ADDR_WATCHDOG_CONTROL;
	wire logic md_wr = i_req.wr && i_req.addr == ADDR_MODE_SUPPLY;
	// soft reset request then a single strobe back
	sequence s_srst;
		md_wr && i_req.data[7:6] == MODE_SOFT_RESET ##1 !md_wr;
	endsequence
	sequence s_pulse;
		o_soft_reset ##1 !o_soft_reset;
	endsequence
	srst_pulse_a: assert property (s_srst |-> s_pulse)
		else $error("soft reset pulse missing");
	csum_refuse_a: assert property (wd_wr && ^i_req.data |=> o_csum_err)
		else $error("odd parity not flagged");
	fail_hold_a: assert property (i_failure_flag |=> o_fail_output)
		else $error("failure did not hold output");
	fail_gate_a: assert property (!i_pin_is_fo && !i_failure_flag
		|=> !o_fail_output) else $error("fail output without cause");
	hw_rsvd_a: assert property (i_req.rd && i_req.addr == ADDR_HW_CTRL
		|=> (o_rdata & 8'h9A) == 8'h00) else $error("hw reserved set");
	wd_rsvd_a: assert property (i_req.rd && i_req.addr == ADDR_WATCHDOG_CONTROL
		|=> !o_rdata[3]) else $error("wd reserved set");
	cp_write_a: assert property (hw_wr
		|=> o_charge_pump_en == $past(i_req.data[HW_CP_BIT]))
		else $error("charge pump bit wrong");
	win_write_a: assert property (wd_wr && !(^i_req.data)
		|=> o_wd_window == $past(i_req.data[WINDOW_TYPE_SELECT_BIT]))
		else $error("window bit wrong");
endmodule
bind sbcwd_ctrl_regs sbcwd_ctrl_regs_chk u_chk (
	.i_mclk, .i_sys_rst, .i_req, .i_pin_is_fo, .i_failure_flag,
	.o_rdata, .o_csum_err, .o_soft_reset, .o_fail_output,
	.o_charge_pump_en, .o_wd_window
);

// ---- tb/sbcwd_host.sv ----
`timescale 1ns/100ps
// host side: single-byte accesses, lines scrambled when idle
module sbcwd_host (
	// clock
	input  wire logic             i_mclk,
	// access out, read data in
	output sbcwd_pkg::sbcwd_req_t o_req,
	input  wire logic [7:0]       i_rdata
);
	import sbcwd_pkg::*;
	initial o_req = '0;
	// released lines flip so stale data never looks valid
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
		@(posedge i_mclk);
		o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
		#1;
	endtask
	task automatic wd_wr(input logic [7:0] d);
		wr(ADDR_WATCHDOG_CONTROL, {^d[6:0], d[6:0]});
	endtask
	// read data is registered on the strobe edge
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'hA5};
		@(posedge i_mclk);
		o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'h5A};
		#1;
		d = i_rdata;
	endtask
endmodule
